// File: shared/pif_pkg.sv
`default_nettype none
package pif_pkg;

  // Bus geometry
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned REG_W = 8;

  // Word-aligned byte offsets
  localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPTION      = 8'h04;
  localparam logic [7:0] OFF_ENABLE_1    = 8'h08;
  localparam logic [7:0] OFF_ENABLE_2    = 8'h0c;
  localparam logic [7:0] OFF_FLAGS_1     = 8'h10;
  localparam logic [7:0] OFF_FLAGS_2     = 8'h14;
  localparam logic [7:0] OFF_EVT_STATUS  = 8'h18;
  localparam logic [7:0] OFF_EVT_CLEAR   = 8'h1c;
  localparam logic [7:0] OFF_EVT_ENABLE  = 8'h20;

  // Global control fields
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;

  // First flag and enable register fields
  localparam int unsigned BIT_GATE      = 7;
  localparam int unsigned BIT_CONV      = 6;
  localparam int unsigned BIT_RX        = 5;
  localparam int unsigned BIT_TX        = 4;
  localparam int unsigned BIT_SYNC      = 3;
  localparam int unsigned BIT_CAPCMP_A  = 2;
  localparam int unsigned BIT_PERIOD    = 1;
  localparam int unsigned BIT_OVERFLOW  = 0;

  // Second flag and enable register field
  localparam int unsigned BIT_CAPCMP_B  = 0;

  // Event status layout: first flag register, then second flag
  localparam int unsigned EVT_W         = 9;
  localparam int unsigned EVT_CAPCMP_B  = 8;

  // Reset values
  localparam logic [7:0] RST_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] RST_OPTION      = 8'h00;
  localparam logic [7:0] RST_ENABLE_1    = 8'h00;
  localparam logic       RST_ENABLE_2    = 1'b0;
  localparam logic       RST_FLAG        = 1'b0;
  localparam logic [8:0] RST_EVT         = 9'h000;

  localparam logic [DAT_W-1:0] DAT_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    CAPCMP_OFF,
    CAPCMP_CAPTURE,
    CAPCMP_COMPARE,
    CAPCMP_PWM
  } capcmp_mode_t;

endpackage : pif_pkg
`default_nettype wire

// File: shared/evt_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface evt_status_if;
  logic [pif_pkg::EVT_W-1:0] evt;
  logic                      clr_we;
  logic [pif_pkg::EVT_W-1:0] clr_data;
  logic                      en_we;
  logic [pif_pkg::EVT_W-1:0] en_data;
  logic [pif_pkg::EVT_W-1:0] status;
  logic [pif_pkg::EVT_W-1:0] enable;
  logic                      irq;

  modport ctrl (
    output evt, clr_we, clr_data, en_we, en_data,
    input  status, enable, irq
  );
  modport unit (
    input  evt, clr_we, clr_data, en_we, en_data,
    output status, enable, irq
  );
endinterface : evt_status_if
`default_nettype wire

// File: rtl/sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output var  logic flag_o
);
  logic flag_reg;
  logic flag_next;

  // Hardware set wins over a software write in the same cycle
  assign flag_next = set_i | (wr_i ? wdata_i : flag_reg);
  assign flag_o    = flag_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule : sticky_flag
`default_nettype wire

// File: rtl/evt_status.sv
`timescale 1ns/1ps
`default_nettype none
module evt_status (
  input  wire logic  clk_sys_i,
  input  wire logic  rst_i,
  evt_status_if.unit st_if
);
  logic [pif_pkg::EVT_W-1:0] status_reg;
  logic [pif_pkg::EVT_W-1:0] status_next;
  logic [pif_pkg::EVT_W-1:0] enable_reg;
  logic [pif_pkg::EVT_W-1:0] enable_next;
  logic [pif_pkg::EVT_W-1:0] clr_mask;
  logic                      irq_reg;

  assign clr_mask    = st_if.clr_we ? st_if.clr_data : pif_pkg::RST_EVT;
  // New event outranks a clear in the same cycle
  assign status_next = st_if.evt | (status_reg & ~clr_mask);
  assign enable_next = st_if.en_we ? st_if.en_data : enable_reg;

  assign st_if.status = status_reg;
  assign st_if.enable = enable_reg;
  assign st_if.irq    = irq_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= pif_pkg::RST_EVT;
      enable_reg <= pif_pkg::RST_EVT;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg    <= |(status_reg & enable_reg);
    end
  end
endmodule : evt_status
`default_nettype wire

// File: rtl/peripheral_interrupt_flags.sv
// What this block does
// - Flags 1 bit 6 sets when a conversion finishes; software clears it.
// - Flags 1 bit 5 reads one while the receive buffer holds data.
// - Flags 1 bit 4 reads one while the transmit buffer is empty.
// - Flags 1 bit 3 sets when a sync port transfer ends; software clears it.
// - Flags 1 bit 2 sets on capture or compare per mode, never in PWM mode.
// - Flags 1 bit 1 sets on a timer B period match; software clears it.
// - Flags 1 bit 0 sets on a timer A overflow; software clears it.
// - Flags capture events whatever the enables hold.
// - Flags 2 implements bit 0 only; bits 7 to 1 read zero, ignore writes.
// - Flags 2 bit 0 sets on capture or compare per mode, never in PWM mode.
// - No flag raises the processor request unless the peripheral enable is set; the event request ignores it.
// - An enable bit at one passes its flag to the request, at zero masks it.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flags (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        conv_done_i,
  input  wire logic        rx_buf_full_i,
  input  wire logic        tx_buf_empty_i,
  input  wire logic        sync_port_done_i,
  input  wire logic [1:0]  capcmp_a_mode_i,
  input  wire logic        capcmp_a_capture_i,
  input  wire logic        capcmp_a_match_i,
  input  wire logic [1:0]  capcmp_b_mode_i,
  input  wire logic        capcmp_b_capture_i,
  input  wire logic        capcmp_b_match_i,
  input  wire logic        period_match_i,
  input  wire logic        timer_a_overflow_i,
  input  wire logic        timer_a_gate_done_i,
  output var  logic [7:0]  timer0_option_o,
  output var  logic        proc_irq_o,
  output var  logic        evt_irq_o
);

  localparam int unsigned RW = pif_pkg::REG_W;
  localparam int unsigned EW = pif_pkg::EVT_W;

  // Bus slave state
  logic          ack_reg;
  logic          ack_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          req;
  logic          wr_commit;
  logic          lane0_wr;

  // Register address hits
  logic          hit_global;
  logic          hit_option;
  logic          hit_enable_1;
  logic          hit_enable_2;
  logic          hit_flags_1;
  logic          hit_flags_2;
  logic          hit_evt_status;
  logic          hit_evt_clear;
  logic          hit_evt_enable;

  // Write strobes
  logic          wr_global;
  logic          wr_option;
  logic          wr_enable_1;
  logic          wr_enable_2;
  logic          wr_flags_1;
  logic          wr_flags_2;

  // Software-visible registers
  logic [RW-1:0] global_ctrl_reg;
  logic [RW-1:0] global_ctrl_next;
  logic [RW-1:0] option_reg;
  logic [RW-1:0] option_next;
  logic [RW-1:0] enable_1_reg;
  logic [RW-1:0] enable_1_next;
  logic          capcmp_b_enable_reg;
  logic          capcmp_b_enable_next;

  // Flags
  logic [RW-1:0] flags_1;
  logic [RW-1:0] flags_2;
  logic [RW-1:0] set_1;
  logic          capcmp_b_flag;
  logic          capcmp_b_set;
  logic [EW-1:0] flags_all;
  logic [EW-1:0] flags_prev_reg;
  logic          evt_armed_reg;
  logic          en_hi_bit;

  // Capture/compare qualification
  pif_pkg::capcmp_mode_t mode_a;
  pif_pkg::capcmp_mode_t mode_b;
  logic          capcmp_a_set;

  // Processor request
  logic          periph_pending;
  logic          proc_irq_reg;
  logic          proc_irq_next;

  // Event status unit
  logic [RW-1:0] evt_status_rd;
  logic [RW-1:0] evt_enable_rd;
  logic          evt_status_hi;
  logic          evt_enable_hi;

  evt_status_if st_if ();

  // Single-wait-state classic slave: ack one cycle after the request
  assign req       = wb_cyc_i & wb_stb_i;
  assign ack_next  = req & ~ack_reg;
  assign wr_commit = req & wb_we_i & ack_reg;
  assign lane0_wr  = wr_commit & wb_sel_i[0];

  assign hit_global     = wb_adr_i == pif_pkg::OFF_GLOBAL_CTRL;
  assign hit_option     = wb_adr_i == pif_pkg::OFF_OPTION;
  assign hit_enable_1   = wb_adr_i == pif_pkg::OFF_ENABLE_1;
  assign hit_enable_2   = wb_adr_i == pif_pkg::OFF_ENABLE_2;
  assign hit_flags_1    = wb_adr_i == pif_pkg::OFF_FLAGS_1;
  assign hit_flags_2    = wb_adr_i == pif_pkg::OFF_FLAGS_2;
  assign hit_evt_status = wb_adr_i == pif_pkg::OFF_EVT_STATUS;
  assign hit_evt_clear  = wb_adr_i == pif_pkg::OFF_EVT_CLEAR;
  assign hit_evt_enable = wb_adr_i == pif_pkg::OFF_EVT_ENABLE;

  assign wr_global   = lane0_wr & hit_global;
  assign wr_option   = lane0_wr & hit_option;
  assign wr_enable_1 = lane0_wr & hit_enable_1;
  assign wr_enable_2 = lane0_wr & hit_enable_2;
  assign wr_flags_1  = lane0_wr & hit_flags_1;
  assign wr_flags_2  = lane0_wr & hit_flags_2;

  assign global_ctrl_next = wr_global ? wb_dat_i[RW-1:0] : global_ctrl_reg;
  assign option_next      = wr_option ? wb_dat_i[RW-1:0] : option_reg;
  assign enable_1_next    = wr_enable_1 ? wb_dat_i[RW-1:0] : enable_1_reg;
  assign capcmp_b_enable_next = wr_enable_2 ?
                                wb_dat_i[pif_pkg::BIT_CAPCMP_B] :
                                capcmp_b_enable_reg;

  // Capture/compare events count only in the matching mode
  assign mode_a = pif_pkg::capcmp_mode_t'(capcmp_a_mode_i);
  assign mode_b = pif_pkg::capcmp_mode_t'(capcmp_b_mode_i);
  assign capcmp_a_set =
    ((mode_a == pif_pkg::CAPCMP_CAPTURE) & capcmp_a_capture_i) |
    ((mode_a == pif_pkg::CAPCMP_COMPARE) & capcmp_a_match_i);
  assign capcmp_b_set =
    ((mode_b == pif_pkg::CAPCMP_CAPTURE) & capcmp_b_capture_i) |
    ((mode_b == pif_pkg::CAPCMP_COMPARE) & capcmp_b_match_i);

  // Set sources ignore every enable bit
  always_comb begin
    set_1 = 8'h00;
    set_1[pif_pkg::BIT_GATE]     = timer_a_gate_done_i;
    set_1[pif_pkg::BIT_CONV]     = conv_done_i;
    set_1[pif_pkg::BIT_SYNC]     = sync_port_done_i;
    set_1[pif_pkg::BIT_CAPCMP_A] = capcmp_a_set;
    set_1[pif_pkg::BIT_PERIOD]   = period_match_i;
    set_1[pif_pkg::BIT_OVERFLOW] = timer_a_overflow_i;
  end

  // Sticky flags, with the two buffer-state bits as live levels
  for (genvar i = 0; i < RW; i++) begin : g_flags_1
    if (i == pif_pkg::BIT_RX) begin : g_rx
      assign flags_1[i] = rx_buf_full_i;
    end else if (i == pif_pkg::BIT_TX) begin : g_tx
      assign flags_1[i] = tx_buf_empty_i;
    end else begin : g_sticky
      sticky_flag #(
        .RESET_VAL (pif_pkg::RST_FLAG)
      ) u_flag (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .set_i     (set_1[i]),
        .wr_i      (wr_flags_1),
        .wdata_i   (wb_dat_i[i]),
        .flag_o    (flags_1[i])
      );
    end
  end

  sticky_flag #(
    .RESET_VAL (pif_pkg::RST_FLAG)
  ) u_capcmp_b_flag (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .set_i     (capcmp_b_set),
    .wr_i      (wr_flags_2),
    .wdata_i   (wb_dat_i[pif_pkg::BIT_CAPCMP_B]),
    .flag_o    (capcmp_b_flag)
  );

  // Only bit 0 exists in the second flag register
  always_comb begin
    flags_2 = 8'h00;
    flags_2[pif_pkg::BIT_CAPCMP_B] = capcmp_b_flag;
  end

  // Request gating
  assign periph_pending = |(flags_1 & enable_1_reg) |
                          (capcmp_b_flag & capcmp_b_enable_reg);
  assign proc_irq_next  = global_ctrl_reg[pif_pkg::BIT_GLOBAL_EN] &
                          global_ctrl_reg[pif_pkg::BIT_PERIPH_EN] &
                          periph_pending;

  // Rising flags feed the event status unit
  // No edges in the first cycle after reset: live levels may start high
  assign flags_all = {capcmp_b_flag, flags_1};
  assign st_if.evt      = evt_armed_reg ? (flags_all & ~flags_prev_reg) :
                                          pif_pkg::RST_EVT;
  assign st_if.clr_we   = lane0_wr & hit_evt_clear;
  assign st_if.clr_data = {wb_dat_i[RW], wb_dat_i[RW-1:0]};
  // Enable bit 8 sits in lane 1 and holds without it
  assign en_hi_bit      = wb_sel_i[1] ? wb_dat_i[RW] :
                                        st_if.enable[pif_pkg::EVT_CAPCMP_B];
  assign st_if.en_we    = lane0_wr & hit_evt_enable;
  assign st_if.en_data  = {en_hi_bit, wb_dat_i[RW-1:0]};

  evt_status u_evt_status (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .st_if     (st_if)
  );

  assign evt_status_rd = st_if.status[RW-1:0];
  assign evt_status_hi = st_if.status[pif_pkg::EVT_CAPCMP_B];
  assign evt_enable_rd = st_if.enable[RW-1:0];
  assign evt_enable_hi = st_if.enable[pif_pkg::EVT_CAPCMP_B];

  // Read mux; unmapped and write-only offsets read zero
  assign rdata_next =
    hit_global     ? {24'h00_0000, global_ctrl_reg} :
    hit_option     ? {24'h00_0000, option_reg} :
    hit_enable_1   ? {24'h00_0000, enable_1_reg} :
    hit_enable_2   ? {31'h0000_0000, capcmp_b_enable_reg} :
    hit_flags_1    ? {24'h00_0000, flags_1} :
    hit_flags_2    ? {24'h00_0000, flags_2} :
    hit_evt_status ? {23'h00_0000, evt_status_hi, evt_status_rd} :
    hit_evt_enable ? {23'h00_0000, evt_enable_hi, evt_enable_rd} :
                     pif_pkg::DAT_ZERO;

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdata_reg;
  assign timer0_option_o = option_reg;
  assign proc_irq_o      = proc_irq_reg;
  assign evt_irq_o       = st_if.irq;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= pif_pkg::DAT_ZERO;
    end else begin
      rdata_reg <= ack_next ? rdata_next : pif_pkg::DAT_ZERO;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      global_ctrl_reg <= pif_pkg::RST_GLOBAL_CTRL;
    end else begin
      global_ctrl_reg <= global_ctrl_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      option_reg <= pif_pkg::RST_OPTION;
    end else begin
      option_reg <= option_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enable_1_reg <= pif_pkg::RST_ENABLE_1;
    end else begin
      enable_1_reg <= enable_1_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      capcmp_b_enable_reg <= pif_pkg::RST_ENABLE_2;
    end else begin
      capcmp_b_enable_reg <= capcmp_b_enable_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flags_prev_reg <= pif_pkg::RST_EVT;
    end else begin
      flags_prev_reg <= flags_all;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      evt_armed_reg <= 1'b0;
    end else begin
      evt_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      proc_irq_reg <= 1'b0;
    end else begin
      proc_irq_reg <= proc_irq_next;
    end
  end

endmodule : peripheral_interrupt_flags
`default_nettype wire

// File: tb/pif_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pif_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_buf_full_i,
  input wire logic        tx_buf_empty_i,
  input wire logic [7:0]  timer0_option_o,
  input wire logic        proc_irq_o
);
  logic [1:0] gp_reg;
  wire        rd_ack = wb_ack_o && !wb_we_i;
  wire        wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];

  // Shadow of the global and peripheral enables
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gp_reg <= 2'h0;
    end else if (wr_ack && wb_adr_i == pif_pkg::OFF_GLOBAL_CTRL) begin
      gp_reg <= wb_dat_i[7:6];
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_timely_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == pif_pkg::DAT_ZERO)
    else $error("read data not zero outside ack");
  option_wr_a: assert property (wr_ack && wb_adr_i == pif_pkg::OFF_OPTION
    |=> timer0_option_o == $past(wb_dat_i[7:0]))
    else $error("option register not written");
  rx_live_a: assert property (
    rd_ack && wb_adr_i == pif_pkg::OFF_FLAGS_1
    |-> wb_dat_o[pif_pkg::BIT_RX] == $past(rx_buf_full_i))
    else $error("receive flag does not follow buffer");
  tx_live_a: assert property (
    rd_ack && wb_adr_i == pif_pkg::OFF_FLAGS_1
    |-> wb_dat_o[pif_pkg::BIT_TX] == $past(tx_buf_empty_i))
    else $error("transmit flag does not follow buffer");
  flags2_upper_a: assert property (
    rd_ack && wb_adr_i == pif_pkg::OFF_FLAGS_2
    |-> wb_dat_o[31:1] == 31'h0000_0000)
    else $error("flags 2 upper bits not zero");
  irq_gate_a: assert property (proc_irq_o |-> $past(gp_reg) == 2'h3)
    else $error("request without global and peripheral enable");
endmodule : pif_monitor

bind peripheral_interrupt_flags pif_monitor mon_u (
  .clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_buf_full_i, .tx_buf_empty_i,
  .timer0_option_o, .proc_irq_o
);
`default_nettype wire

// File: tb/pif_event_model.sv
`timescale 1ns/1ps
`default_nettype none
module pif_event_model (
  input  wire logic       clk_sys_i,
  output var  logic [8:0] pulse_o,
  output var  logic       rx_full_o,
  output var  logic       tx_empty_o
);
  initial begin
    pulse_o = 9'h000;
    rx_full_o = 1'b0;
    tx_empty_o = 1'b1;
  end

  // One-cycle event pulse launched right after an edge
  task automatic fire(input int i);
    @(posedge clk_sys_i);
    pulse_o[i] <= 1'b1;
    @(posedge clk_sys_i);
    pulse_o <= 9'h000;
  endtask : fire

  task automatic levels(input logic r, input logic t);
    @(posedge clk_sys_i);
    rx_full_o <= r;
    tx_empty_o <= t;
  endtask : levels
endmodule : pif_event_model
`default_nettype wire

// File: tb/peripheral_interrupt_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_flags_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic [1:0]  mode_a = 2'h1;
  logic [1:0]  mode_b = 2'h3;
  wire  [31:0] rdat;
  wire  [8:0]  ev;
  wire  [7:0]  opt;
  wire         ack, rx, tx, pirq, eirq;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          bits[6] = '{7, 6, 3, 2, 1, 0};
  logic [8:0]  exp;

  always #5 clk = ~clk;

  pif_event_model src_u (.clk_sys_i(clk), .pulse_o(ev), .rx_full_o(rx),
    .tx_empty_o(tx));

  peripheral_interrupt_flags dut_u (.clk_sys_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .conv_done_i(ev[6]), .rx_buf_full_i(rx), .tx_buf_empty_i(tx),
    .sync_port_done_i(ev[3]), .capcmp_a_mode_i(mode_a),
    .capcmp_a_capture_i(ev[2]), .capcmp_a_match_i(ev[5]),
    .capcmp_b_mode_i(mode_b), .capcmp_b_capture_i(ev[8]),
    .capcmp_b_match_i(ev[4]), .period_match_i(ev[1]),
    .timer_a_overflow_i(ev[0]), .timer_a_gate_done_i(ev[7]),
    .timer0_option_o(opt), .proc_irq_o(pirq), .evt_irq_o(eirq));

  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [8:0] d,
                    input logic [3:0] m = 4'hf);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    sel <= m;
    adr <= a;
    wdat <= 32'(d);
    do @(posedge clk); while (ack !== 1'b1);
    if (!w) chk($sformatf("reg %h", a), rdat, 32'(d));
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic irq(input logic e, input logic s);
    repeat (3) @(posedge clk);
    chk(e ? "evt_irq" : "proc_irq", 32'(e ? eirq : pirq), 32'(s));
  endtask : irq

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    #100_000;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) wb(0, 8'(4 * i), i == 4 ? 9'h010 : 9'h000);
    wb(1, pif_pkg::OFF_OPTION, 9'h0a5);
    wb(0, pif_pkg::OFF_OPTION, 9'h0a5);
    chk("timer0_option_o", 32'(opt), 32'h0000_00a5);
    wb(1, pif_pkg::OFF_FLAGS_2, 9'h0fe);
    wb(0, pif_pkg::OFF_FLAGS_2, 9'h000);
    exp = 9'h010;
    foreach (bits[k]) begin
      src_u.fire(bits[k]);
      exp[bits[k]] = 1'b1;
      wb(0, pif_pkg::OFF_FLAGS_1, exp);
    end
    wb(1, pif_pkg::OFF_FLAGS_1, 9'h000);
    wb(0, pif_pkg::OFF_FLAGS_1, 9'h010);
    mode_a <= 2'h3;
    src_u.fire(2);
    src_u.fire(5);
    wb(0, pif_pkg::OFF_FLAGS_1, 9'h010);
    mode_a <= 2'h2;
    src_u.fire(5);
    wb(0, pif_pkg::OFF_FLAGS_1, 9'h014);
    src_u.fire(8);
    src_u.fire(4);
    wb(0, pif_pkg::OFF_FLAGS_2, 9'h000);
    mode_b <= 2'h1;
    src_u.fire(8);
    wb(0, pif_pkg::OFF_FLAGS_2, 9'h001);
    src_u.levels(1'b1, 1'b0);
    wb(0, pif_pkg::OFF_FLAGS_1, 9'h024);
    wb(1, pif_pkg::OFF_FLAGS_1, 9'h000);
    wb(0, pif_pkg::OFF_FLAGS_1, 9'h020);
    src_u.levels(1'b0, 1'b1);
    wb(1, pif_pkg::OFF_FLAGS_2, 9'h000);
    src_u.fire(0);
    wb(1, pif_pkg::OFF_ENABLE_1, 9'h001);
    wb(1, pif_pkg::OFF_GLOBAL_CTRL, 9'h080);
    irq(0, 0);
    wb(1, pif_pkg::OFF_GLOBAL_CTRL, 9'h0c0);
    irq(0, 1);
    wb(1, pif_pkg::OFF_GLOBAL_CTRL, 9'h000, 4'he);
    wb(0, pif_pkg::OFF_GLOBAL_CTRL, 9'h0c0);
    wb(1, pif_pkg::OFF_ENABLE_1, 9'h000);
    irq(0, 0);
    wb(1, pif_pkg::OFF_ENABLE_2, 9'h0ff);
    wb(0, pif_pkg::OFF_ENABLE_2, 9'h001);
    mode_b <= 2'h2;
    src_u.fire(4);
    irq(0, 1);
    wb(1, pif_pkg::OFF_FLAGS_1, 9'h000);
    wb(1, pif_pkg::OFF_EVT_CLEAR, 9'h1ff);
    wb(1, pif_pkg::OFF_EVT_ENABLE, 9'h1ff, 4'h1);
    wb(0, pif_pkg::OFF_EVT_ENABLE, 9'h0ff);
    wb(1, pif_pkg::OFF_EVT_ENABLE, 9'h001);
    src_u.fire(0);
    irq(1, 1);
    wb(0, pif_pkg::OFF_EVT_STATUS, 9'h001);
    wb(1, pif_pkg::OFF_EVT_CLEAR, 9'h001);
    irq(1, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(0, pif_pkg::OFF_EVT_STATUS, 9'h000);
    wb(0, pif_pkg::OFF_GLOBAL_CTRL, 9'h000);
    wb(0, pif_pkg::OFF_FLAGS_2, 9'h000);
    irq(0, 0);
    final_report();
  end
endmodule : peripheral_interrupt_flags_tb
`default_nettype wire
